//--- shared/dma_status_params.svh
// Purpose: Offsets, field positions, reset values for the DMA status block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef DMA_STATUS_PARAMS_SVH
`define DMA_STATUS_PARAMS_SVH
`define OFS_COLLISION      12'h000
`define OFS_CHAN_BUF       12'h004
`define OFS_RECENT_ADDR    12'h008
`define OFS_IRQ_STATUS     12'h00c
`define OFS_IRQ_MASK       12'h010
`define OFS_MODE           12'h014
`define LAST_CH_LSB        8
`define LAST_CH_RESET      4'hf
`define MODE_ONESHOT_PP    2'h3
`define MODE_CONT_PP       2'h2
`define IRQ_BIT_COLL       0
`define IRQ_BIT_XFER       1
`define IRQ_BIT_DONE       2
`endif

//--- shared/dma_status_pkg.sv
// Purpose: Types shared by the DMA status block.
// Assumes: Eight channels.
// Notes:   Constants live in the params header.
package dma_status_pkg;
   typedef logic [15:0] half_word_type;
   typedef logic [7:0]  chan_vec_type;
   typedef logic [2:0]  chan_num_type;
   typedef enum logic [1:0] {
      MODE_CONT, MODE_ONESHOT, MODE_CONT_PING, MODE_ONESHOT_PING
   } chan_mode_type;
endpackage

//--- design/dma_status.sv
// Purpose: Shared collision, last-channel, ping-pong and address status of an
//          eight-channel DMA controller, reached over APB.
// Assumes: Channel engines pulse events synchronous to core_clk.
// Notes:   Zero wait states; unmapped reads return zero and set pslverr.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "dma_status_params.svh"

module dma_status #(
   parameter int CHANNELS = 8
) (
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [11:0]                 paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic                             pready,
   output logic [31:0]                      prdata,
   output logic                             pslverr,
   input  wire dma_status_pkg::chan_vec_type periph_collision,
   input  wire dma_status_pkg::chan_vec_type ram_collision,
   input  wire logic                        xfer_valid,
   input  wire dma_status_pkg::chan_num_type xfer_channel,
   input  wire dma_status_pkg::half_word_type xfer_ram_address,
   input  wire dma_status_pkg::chan_vec_type block_done,
   output dma_status_pkg::chan_vec_type     pingpong_buffer_status,
   output dma_status_pkg::chan_vec_type     oneshot_finished,
   output logic                             irq
);
   import dma_status_pkg::*;

   // Software-visible state and ping-pong bookkeeping.
   chan_vec_type  periph_write_collision_flag;
   chan_vec_type  ram_write_collision_flag;
   logic [3:0]    last_active_channel;
   half_word_type recent_ram_address;
   logic [2:0]    irq_status;
   logic [2:0]    irq_mask;
   logic [15:0]   mode_bits;
   chan_vec_type  buffer_count;

   // Access decode; a write lands only in the access phase with pready high.
   wire access    = psel && penable && pready;
   wire wr_access = access && pwrite;
   wire sel_coll  = (paddr == `OFS_COLLISION);
   wire sel_chbuf = (paddr == `OFS_CHAN_BUF);
   wire sel_addr  = (paddr == `OFS_RECENT_ADDR);
   wire sel_ists  = (paddr == `OFS_IRQ_STATUS);
   wire sel_imask = (paddr == `OFS_IRQ_MASK);
   wire sel_mode  = (paddr == `OFS_MODE);
   wire mapped    = sel_coll || sel_chbuf || sel_addr || sel_ists || sel_imask || sel_mode;
   wire wr_coll   = wr_access && sel_coll;
   wire wr_ists   = wr_access && sel_ists && pstrb[0];
   wire wr_imask  = wr_access && sel_imask && pstrb[0];
   // Mode writes honour byte lanes, so four channels can be set without touching the rest.
   wire [1:0] wr_mode_lanes = {2{wr_access && sel_mode}} & pstrb[1:0];
   wire [15:0] mode_mask = {{8{wr_mode_lanes[1]}}, {8{wr_mode_lanes[0]}}};

   // Write-one-to-clear masks honour the byte lanes.
   wire chan_vec_type clr_periph = wr_coll && pstrb[1] ? pwdata[15:8] : 8'h00;
   wire chan_vec_type clr_ram    = wr_coll && pstrb[0] ? pwdata[7:0]  : 8'h00;

   // Set beats clear, so an event in the clearing cycle survives.
   wire chan_vec_type next_periph = (periph_write_collision_flag & ~clr_periph)
                                    | periph_collision;
   wire chan_vec_type next_ram    = (ram_write_collision_flag & ~clr_ram)
                                    | ram_collision;

   // Interrupt events.
   wire [2:0] irq_events = {|block_done, xfer_valid, |(periph_collision | ram_collision)};
   wire [2:0] next_irq_status = (irq_status & ~(wr_ists ? pwdata[2:0] : 3'h0)) | irq_events;

   // Ping-pong bookkeeping per channel.
   chan_vec_type  next_pp;
   chan_vec_type  next_count;
   chan_vec_type  next_finished;
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_chan
         wire [1:0] mode = mode_bits[2*g+1:2*g];
         wire pp_mode = mode == `MODE_ONESHOT_PP || mode == `MODE_CONT_PP;
         wire oneshot = mode == `MODE_ONESHOT_PP;
         wire finish  = oneshot && buffer_count[g];
         // Buffer selection flips per completed block; one-shot stops after the second.
         assign next_pp[g] = (pp_mode && block_done[g] && !oneshot_finished[g])
                             ? (finish ? 1'b0 : ~pingpong_buffer_status[g])
                             : (pp_mode ? pingpong_buffer_status[g] : 1'b0);
         assign next_count[g] = (oneshot && block_done[g] && !oneshot_finished[g])
                                ? ~buffer_count[g] : (oneshot ? buffer_count[g] : 1'b0);
         // Finished drops one cycle after the mode leaves one-shot, restarting the pair.
         assign next_finished[g] = oneshot && (oneshot_finished[g]
                                   || (block_done[g] && finish));
      end
   endgenerate

   // Read mux; unimplemented bits read zero.
   // Unmapped offsets also read zero, so a stray read never shows stale data.
   wire [31:0] rd_value =
      sel_coll  ? {16'h0000, periph_write_collision_flag, ram_write_collision_flag} :
      sel_chbuf ? {20'h00000, last_active_channel, pingpong_buffer_status} :
      sel_addr  ? {16'h0000, recent_ram_address} :
      sel_ists  ? {29'h0, irq_status} :
      sel_imask ? {29'h0, irq_mask} :
      sel_mode  ? {16'h0000, mode_bits} : 32'h0;

   // Collision flags.
   // Only an event can raise a flag; software can only lower it.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         periph_write_collision_flag <= 8'h00;
         ram_write_collision_flag    <= 8'h00;
      end else begin
         periph_write_collision_flag <= next_periph;
         ram_write_collision_flag    <= next_ram;
      end
   end

   // Last channel and most recent address follow each transfer.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         last_active_channel <= `LAST_CH_RESET;
         recent_ram_address  <= 16'h0000;
      end else if (xfer_valid) begin
         last_active_channel <= {1'b0, xfer_channel};
         recent_ram_address  <= xfer_ram_address;
      end
   end

   // Ping-pong state.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pingpong_buffer_status <= 8'h00;
         buffer_count           <= 8'h00;
         oneshot_finished       <= 8'h00;
      end else begin
         pingpong_buffer_status <= next_pp;
         buffer_count           <= next_count;
         oneshot_finished       <= next_finished;
      end
   end

   // Software registers and interrupt.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_status <= 3'h0;
         irq_mask   <= 3'h0;
         mode_bits  <= 16'h0000;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq_mask   <= wr_imask ? pwdata[2:0] : irq_mask;
         mode_bits  <= (mode_bits & ~mode_mask) | (pwdata[15:0] & mode_mask);
         irq        <= |(next_irq_status & irq_mask);
      end
   end

   // APB answer; ready is registered off the setup cycle, so the access phase is
   // answered at once and no wait state is ever inserted.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         prdata  <= (psel && !penable && !pwrite) ? rd_value : prdata;
         pslverr <= psel && !penable && !mapped;
      end
   end

   // Checks. Every property is disabled while reset is low, so the reset values
   // themselves are left to the bench, which reads them back over the bus.
   // Sampled values lag the flip-flops by one edge, which the implications allow for.

   // A transfer loads its channel number with the top bit clear.
   property p_last_load;
      @(posedge core_clk) disable iff (!rst_n)
      xfer_valid |=> last_active_channel == {1'b0, $past(xfer_channel)};
   endproperty
   a_last_load: assert property (p_last_load) else $error("last channel wrong");

   // The only code with the top bit set is the after-reset value.
   property p_last_never_reserved;
      @(posedge core_clk) disable iff (!rst_n)
      last_active_channel[3] |-> last_active_channel == 4'hf;
   endproperty
   a_last_never_reserved: assert property (p_last_never_reserved) else $error("reserved");

   // Without a transfer the field keeps its value, so 1111 survives until the first one.
   property p_last_holds;
      @(posedge core_clk) disable iff (!rst_n)
      !$past(xfer_valid) && $past(rst_n) |-> $stable(last_active_channel);
   endproperty
   a_last_holds: assert property (p_last_holds) else $error("last channel moved");

   // A peripheral collision pulse leaves its flag standing one edge later.
   property p_periph_set;
      @(posedge core_clk) disable iff (!rst_n)
      periph_collision != 8'h00 |=> (periph_write_collision_flag & $past(periph_collision))
                                    == $past(periph_collision);
   endproperty
   a_periph_set: assert property (p_periph_set) else $error("periph flag lost");

   // A RAM collision pulse leaves its flag standing one edge later.
   property p_ram_set;
      @(posedge core_clk) disable iff (!rst_n)
      ram_collision != 8'h00 |=> (ram_write_collision_flag & $past(ram_collision))
                                 == $past(ram_collision);
   endproperty
   a_ram_set: assert property (p_ram_set) else $error("ram flag lost");

   // Without a clearing write no peripheral flag may fall.
   property p_periph_sticky;
      @(posedge core_clk) disable iff (!rst_n)
      !wr_coll |=> (periph_write_collision_flag & $past(periph_write_collision_flag))
                   == $past(periph_write_collision_flag);
   endproperty
   a_periph_sticky: assert property (p_periph_sticky) else $error("periph dropped");

   // Without a clearing write no RAM flag may fall.
   property p_ram_sticky;
      @(posedge core_clk) disable iff (!rst_n)
      !wr_coll |=> (ram_write_collision_flag & $past(ram_write_collision_flag))
                   == $past(ram_write_collision_flag);
   endproperty
   a_ram_sticky: assert property (p_ram_sticky) else $error("ram flag dropped");

   // With no event pending no flag may rise, whatever software writes.
   property p_no_sw_set;
      @(posedge core_clk) disable iff (!rst_n)
      periph_collision == 8'h00 && ram_collision == 8'h00 |=>
         (periph_write_collision_flag & ~$past(periph_write_collision_flag)) == 8'h00
         && (ram_write_collision_flag & ~$past(ram_write_collision_flag)) == 8'h00;
   endproperty
   a_no_sw_set: assert property (p_no_sw_set) else $error("flag set by write");

   // Each transfer records its RAM address.
   property p_addr_load;
      @(posedge core_clk) disable iff (!rst_n)
      xfer_valid |=> recent_ram_address == $past(xfer_ram_address);
   endproperty
   a_addr_load: assert property (p_addr_load) else $error("address not loaded");

   // Between transfers the address stands, and bus writes cannot move it.
   property p_addr_holds;
      @(posedge core_clk) disable iff (!rst_n)
      !xfer_valid |=> $stable(recent_ram_address);
   endproperty
   a_addr_holds: assert property (p_addr_holds) else $error("address moved");

   // Software writes to the buffer status word cannot move the ping-pong bits.
   property p_pp_readonly;
      @(posedge core_clk) disable iff (!rst_n)
      wr_access && sel_chbuf && block_done == 8'h00 |=> $stable(pingpong_buffer_status);
   endproperty
   a_pp_readonly: assert property (p_pp_readonly) else $error("pp written");

   // Once channel 0 has finished its one-shot, further blocks leave the buffer alone.
   property p_oneshot_stop;
      @(posedge core_clk) disable iff (!rst_n)
      oneshot_finished[0] && block_done[0] |=> $stable(pingpong_buffer_status[0]);
   endproperty
   a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot buffer moved");

   // A finished one-shot channel always rests on the primary buffer.
   property p_finished_rests;
      @(posedge core_clk) disable iff (!rst_n)
      (oneshot_finished & pingpong_buffer_status) == 8'h00;
   endproperty
   a_finished_rests: assert property (p_finished_rests) else $error("rest wrong");

   // In continuous ping-pong every completed block swaps the buffer, except while the channel's one-shot finish is still standing.
   property p_pp_flip;
      @(posedge core_clk) disable iff (!rst_n)
      mode_bits[1:0] == `MODE_CONT_PP && block_done[0] && !oneshot_finished[0] |=>
         pingpong_buffer_status[0] != $past(pingpong_buffer_status[0]);
   endproperty
   a_pp_flip: assert property (p_pp_flip) else $error("pp not swapped");

   // Outside ping-pong modes the status bit is held at the primary buffer.
   property p_pp_no_mode;
      @(posedge core_clk) disable iff (!rst_n)
      mode_bits[1] == 1'b0 |=> pingpong_buffer_status[0] == 1'b0;
   endproperty
   a_pp_no_mode: assert property (p_pp_no_mode) else $error("pp without mode");

   // Main scenarios that the bench should reach.
   c_transfer: cover property (@(posedge core_clk) disable iff (!rst_n) xfer_valid);
   c_collision: cover property (@(posedge core_clk) disable iff (!rst_n) |next_ram);
   c_finished: cover property (@(posedge core_clk) disable iff (!rst_n) |oneshot_finished);
   c_irq: cover property (@(posedge core_clk) disable iff (!rst_n) irq);
   c_cont_flip: cover property (@(posedge core_clk) disable iff (!rst_n)
                                mode_bits[1:0] == `MODE_CONT_PP && block_done[0]);
endmodule

//--- testbench/dma_event_source.sv
// Purpose: Model of the channels, CPU and peripherals that raise status events.
// Assumes: Events are one-cycle pulses launched just after a rising edge.
// Notes:   Idle channel and address lines show inverted values, never stale ones.
`timescale 1ns/1ps
module dma_event_source (
   input  wire logic                   core_clk,
   output dma_status_pkg::chan_vec_type  periph_collision,
   output dma_status_pkg::chan_vec_type  ram_collision,
   output logic                        xfer_valid,
   output dma_status_pkg::chan_num_type  xfer_channel,
   output dma_status_pkg::half_word_type xfer_ram_address,
   output dma_status_pkg::chan_vec_type  block_done
);
   import dma_status_pkg::*;

   // Quiet lines at time zero so no input is unknown.
   initial begin
      {periph_collision, ram_collision, block_done} = '0;
      {xfer_valid, xfer_channel, xfer_ram_address} = '0;
   end

   // One collision pulse on both buses.
   task automatic collide(input chan_vec_type p, input chan_vec_type x);
      @(posedge core_clk);
      periph_collision <= p;
      ram_collision <= x;
      @(posedge core_clk);
      periph_collision <= '0;
      ram_collision <= '0;
   endtask

   // One data transfer; the lines are inverted once it is over.
   task automatic xfer(input chan_num_type c, input half_word_type a);
      @(posedge core_clk);
      xfer_valid <= 1'h1;
      xfer_channel <= c;
      xfer_ram_address <= a;
      @(posedge core_clk);
      xfer_valid <= 1'h0;
      xfer_channel <= ~c;
      xfer_ram_address <= ~a;
   endtask

   // Block completion pulse for the channels given.
   task automatic finish_block(input chan_vec_type v);
      @(posedge core_clk);
      block_done <= v;
      @(posedge core_clk);
      block_done <= '0;
   endtask
endmodule

//--- testbench/test_dma_status.sv
// Purpose: Self-checking bench of the DMA status block over APB.
// Assumes: Zero wait states are not relied on; every access waits for pready.
// Notes:   Event partner is a separate model driven through its tasks.
`timescale 1ns/1ps
`include "dma_status_params.svh"
module test_dma_status;
   import dma_status_pkg::*;
   logic          core_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, e, xfer_valid;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, r;
   logic [3:0]    pstrb;
   chan_vec_type  periph_collision, ram_collision, block_done;
   chan_vec_type  pingpong_buffer_status, oneshot_finished;
   chan_num_type  xfer_channel;
   half_word_type xfer_ram_address;
   int            n_mismatch = 0;
   int            comparisons = 0;

   dma_status #(.CHANNELS(8)) uut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .pready, .prdata, .pslverr, .periph_collision, .ram_collision,
      .xfer_valid, .xfer_channel, .xfer_ram_address, .block_done,
      .pingpong_buffer_status, .oneshot_finished, .irq);
   dma_event_source src (.core_clk, .periph_collision, .ram_collision, .xfer_valid,
      .xfer_channel, .xfer_ram_address, .block_done);

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; request held until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d = '0);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (pready !== 1'h1) begin
         n_mismatch++;
         report_and_stop();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // Free-running 50 MHz clock.
   initial begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end

   // A hang counts as a failure and ends the run the usual way.
   initial begin
      repeat (3000) @(posedge core_clk);
      n_mismatch++;
      report_and_stop();
   end

   // Main sequence: reset values, collisions, interrupt, transfers, ping-pong, errors.
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hf;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'h1;
      apb(0, `OFS_COLLISION); chk("coll_rst", r, 32'h0);
      apb(0, `OFS_CHAN_BUF); chk("cbuf_rst", r, 32'h0f00);
      apb(0, `OFS_RECENT_ADDR); chk("addr_rst", r, 32'h0);
      apb(1, `OFS_COLLISION, 32'hffff);
      apb(0, `OFS_COLLISION); chk("coll_wr", r, 32'h0);
      src.collide(8'h81, 8'h42);
      repeat (2) @(posedge core_clk);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      apb(0, `OFS_COLLISION); chk("coll_set", r, 32'h8142);
      repeat (5) @(posedge core_clk);
      apb(0, `OFS_COLLISION); chk("coll_hold", r, 32'h8142);
      apb(1, `OFS_COLLISION, 32'h0102);
      apb(0, `OFS_COLLISION); chk("coll_clr", r, 32'h8040);
      apb(1, `OFS_IRQ_MASK, 32'h1);
      repeat (2) @(posedge core_clk);
      chk("irq_on", {31'h0, irq}, 32'h1);
      apb(1, `OFS_COLLISION, 32'hffff);
      apb(1, `OFS_IRQ_STATUS, 32'h7);
      repeat (2) @(posedge core_clk);
      chk("irq_off", {31'h0, irq}, 32'h0);
      apb(0, `OFS_COLLISION); chk("coll_all", r, 32'h0);
      apb(1, `OFS_CHAN_BUF, 32'hffffffff);
      apb(0, `OFS_CHAN_BUF); chk("cbuf_ro", r, 32'h0f00);
      for (int i = 7; i >= 0; i--) begin
         src.xfer(i[2:0], 16'hc3a0 ^ 16'(i));
         apb(0, `OFS_CHAN_BUF); chk("last_ch", r, 32'(i) << 8);
         apb(0, `OFS_RECENT_ADDR); chk("addr", r, 32'(16'hc3a0 ^ 16'(i)));
      end
      apb(1, `OFS_RECENT_ADDR, 32'hffff);
      apb(0, `OFS_RECENT_ADDR); chk("addr_ro", r, 32'hc3a0);
      apb(1, `OFS_MODE, {30'h0, `MODE_ONESHOT_PP});
      src.finish_block(8'h03);
      @(posedge core_clk);
      chk("pp_first", {24'h0, pingpong_buffer_status}, 32'h01);
      apb(0, `OFS_CHAN_BUF); chk("pp_reg", r, 32'h01);
      src.finish_block(8'h01);
      @(posedge core_clk);
      chk("pp_second", {24'h0, pingpong_buffer_status}, 32'h0);
      chk("oneshot_done", {24'h0, oneshot_finished}, 32'h01);
      src.finish_block(8'h01);
      @(posedge core_clk);
      chk("pp_stopped", {24'h0, pingpong_buffer_status}, 32'h0);
      chk("oneshot_kept", {24'h0, oneshot_finished}, 32'h01);
      apb(1, `OFS_MODE, {30'h0, `MODE_CONT_PP});
      repeat (2) @(posedge core_clk);
      chk("oneshot_clr", {24'h0, oneshot_finished}, 32'h0);
      for (int k = 1; k <= 3; k++) begin
         src.finish_block(8'h01);
         @(posedge core_clk);
         chk("pp_cont", {24'h0, pingpong_buffer_status}, 32'(k % 2));
      end
      apb(0, `OFS_IRQ_STATUS); chk("irq_sts", r, 32'h6);
      rst_n <= 1'h0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'h1;
      apb(0, `OFS_CHAN_BUF); chk("cbuf_rst2", r, 32'h0f00);
      apb(0, 12'h020); chk("unmapped", {r[30:0], e}, 32'h1);
      report_and_stop();
   end
endmodule
